// [rtl/nv_access_pkg.sv]
// Shared constants and types for the parameter-memory window block
package nv_access_pkg;

    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_SUBCMD_LO = 8'h00;
    localparam logic [7:0] CMD_SUBCMD_HI = 8'h01;
    localparam logic [7:0] CMD_SUBCLASS  = 8'h3E;
    localparam logic [7:0] CMD_BLOCK     = 8'h3F;
    localparam logic [7:0] CMD_WIN_BASE  = 8'h40;
    localparam logic [7:0] CMD_WIN_LAST  = 8'h5F;
    localparam logic [7:0] CMD_CHECKSUM  = 8'h60;
    localparam logic [7:0] CMD_WIN_MODE  = 8'h61;

    // ----------------------------------------
    // Values, subcommands and fields
    // ----------------------------------------
    localparam int          WIN_BYTES        = 32;
    localparam logic [7:0]  WIN_MODE_GENERAL = 8'h00;
    localparam logic [7:0]  CHECK_FULL       = 8'hFF;
    localparam logic [15:0] SUBCMD_SEAL      = 16'h0020;
    localparam logic [15:0] SUBCMD_RESET     = 16'h0041;
    localparam logic [15:0] SUBCMD_BOOT      = 16'h0F00;
    localparam logic [7:0]  INFO_SUBCLASS    = 8'h3A;
    localparam logic [7:0]  INFO_IDX_A       = 8'h01;
    localparam logic [7:0]  INFO_IDX_C       = 8'h03;
    localparam logic [7:0]  KEY_SUBCLASS     = 8'h70;
    localparam int          STAT_SEALED_BIT  = 0;
    localparam int          STAT_FAS_BIT     = 1;
    localparam int          STAT_BOOT_BIT    = 2;
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam logic [5:0]  CNT_RST          = 6'h00;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {SEC_SEALED, SEC_OPEN_MODE, SEC_FULL, SEC_BOOT} sec_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_COMMIT} nv_state_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmd_req_s;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [20:0] addr;
        logic [7:0]  wdata;
    } nv_req_s;

    localparam nv_req_s NV_REQ_RST = '{rd: 1'b0, wr: 1'b0, addr: 21'h000000, wdata: 8'h00};

endpackage

// [rtl/nv_window_sum.sv]
// Checksum of the command-space window: full scale minus byte sum
`timescale 1ns/1ps
module nv_window_sum
    import nv_access_pkg::*;
#(
    parameter int NBYTES = WIN_BYTES
)
(
    // Window contents, byte 0 in the low bits
    input  wire logic [NBYTES*8-1:0] win,
    // Expected checksum
    output      logic [7:0]          chk
);

    logic [7:0] sum;

    always_comb
    begin
        sum = 8'h00;
        for (int i = 0; i < NBYTES; i++)
        begin
            sum = 8'(sum + win[i*8 +: 8]);
        end
        chk = 8'(CHECK_FULL - sum);
    end

endmodule // nv_window_sum

// [rtl/nv_window_access.sv]
// Parameter-memory window, block commit and security modes
//
// Function
// - Window-mode zero selects general memory block paging by subclass and block while not locked.
// - Subclass command picks which parameter subclass the window maps.
// - Block index selects a 32-byte slice: index n covers offsets 32n..32n+31.
// - Offset appears at window address 0x40 plus offset mod 32, bytewise.
// - Commit to memory only after a correct checksum write.
// - Valid checksum is 255 minus the 8-bit sum of window bytes.
// - Reset subcommand applies new values; a locked device stays locked.
// - Seal subcommand moves an open device into locked mode.
// - Short blocks commit only written bytes; others stay unchanged.
// - No range checking on written parameter values.
// - Open general mode reaches the info block as subclass 58.
// - Locked or nonzero mode: index 1..3 loads info block A, B or C.
// - Locked mode refuses writes to info block A.
// - Four modes: full and open read-write, locked read-write except info block A, boot none.
// - Only full access may enter boot mode or rewrite keys.
// - Key pair words must be consecutive; any other word voids it.
// - Sealed status bit clears when open-mode keys are received.
// - Full access keys clear the unrestricted-access flag.
// - Key words are stored in memory and rewritable only in full access.
// - Subcommand word written low byte at 0x00, then high byte at 0x01.
// - Subclass command ignored while locked.
`timescale 1ns/1ps
module nv_window_access
    import nv_access_pkg::*;
#(
    parameter int          NBYTES       = WIN_BYTES,
    parameter logic [15:0] UNSEAL_KEY0  = 16'h1111,
    parameter logic [15:0] UNSEAL_KEY1  = 16'h2222,
    parameter logic [15:0] FULL_KEY0    = 16'h3333,
    parameter logic [15:0] FULL_KEY1    = 16'h4444
)
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Command space
    input  wire cmd_req_s   CMD_REQ,
    output      logic [7:0] CMD_RDATA,
    // Non-volatile memory port
    output      nv_req_s    NV_REQ,
    input  wire logic [7:0] NV_RDATA,
    // Status
    output      logic       BUSY,
    output      logic       SEALED_STATUS,
    output      logic       FAS_FLAG,
    output      logic       BOOT_MODE,
    output      logic       GAUGE_RESET
);

    localparam logic [5:0] LOAD_LAST = 6'(NBYTES + 1);
    localparam logic [5:0] COMMIT_LAST = 6'(NBYTES - 1);

    // ----------------------------------------
    // State
    // ----------------------------------------
    sec_mode_e   sec_q, sec_d;
    nv_state_e   st_q, st_d;
    logic [7:0]  win_q [NBYTES];
    logic [NBYTES*8-1:0] win_flat;
    logic [NBYTES-1:0]   dirty_q;
    logic [7:0]  subclass_q, block_q, mode_sel_q, sub_lo_q, rdata_d;
    logic [7:0]  page_sub_q, page_blk_q, chk;
    logic [5:0]  cnt_q, cnt_d;
    logic        win_valid_q, info_a_q, rd_tag_vld_q;
    logic [4:0]  rd_tag_idx_q;
    logic [1:0]  key_step_q, key_step_d;
    logic [15:0] ukey0_q, ukey1_q, fkey0_q, fkey1_q;
    nv_req_s     nv_d;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire        idle      = (st_q == ST_IDLE);
    wire        wr_ok     = CMD_REQ.wr & idle;
    wire        in_win    = (CMD_REQ.addr >= CMD_WIN_BASE) && (CMD_REQ.addr <= CMD_WIN_LAST);
    wire [4:0]  win_idx   = CMD_REQ.addr[4:0];
    wire        sealed    = (sec_q == SEC_SEALED);
    wire        open_mode = (sec_q == SEC_OPEN_MODE) || (sec_q == SEC_FULL);
    wire        info_sel  = sealed | (mode_sel_q != WIN_MODE_GENERAL);
    wire        word_stb  = wr_ok && (CMD_REQ.addr == CMD_SUBCMD_HI);
    wire [15:0] word      = {CMD_REQ.wdata, sub_lo_q};
    wire        blk_wr    = wr_ok && (CMD_REQ.addr == CMD_BLOCK) && (sec_q != SEC_BOOT);
    wire        info_ok   = (CMD_REQ.wdata >= INFO_IDX_A) && (CMD_REQ.wdata <= INFO_IDX_C);
    wire        load_go   = blk_wr && (info_sel ? info_ok : open_mode);
    wire        win_ok    = win_valid_q && (sec_q != SEC_BOOT);
    wire        win_wr    = wr_ok && in_win && win_ok && !(sealed && info_a_q);
    wire        key_page  = (page_sub_q == KEY_SUBCLASS) && (page_blk_q == RST_BYTE);
    wire        key_deny  = key_page && (sec_q != SEC_FULL);
    wire        chk_wr    = wr_ok && (CMD_REQ.addr == CMD_CHECKSUM);
    wire        commit_go = chk_wr && win_ok && (CMD_REQ.wdata == chk)
                            && !(sealed && info_a_q) && !key_deny;
    wire        ukey0_hit = (word == {ukey0_q[7:0], ukey0_q[15:8]});
    wire        ukey1_hit = (word == {ukey1_q[7:0], ukey1_q[15:8]});
    wire        fkey0_hit = (word == {fkey0_q[7:0], fkey0_q[15:8]});
    wire        fkey1_hit = (word == {fkey1_q[7:0], fkey1_q[15:8]});
    wire        unseal_ok = word_stb && sealed && (key_step_q == 2'd1) && ukey1_hit;
    wire        full_ok   = word_stb && (sec_q == SEC_OPEN_MODE) && (key_step_q == 2'd2) && fkey1_hit;
    wire        ld_cap    = rd_tag_vld_q && (st_q == ST_LOAD);

    genvar g;
    generate
        for (g = 0; g < NBYTES; g++)
        begin : g_win
            assign win_flat[g*8 +: 8] = win_q[g];
            // Window byte: loaded from memory or written by host, any value kept
            always_ff @(posedge CLK or negedge RST_N)
            begin
                if (!RST_N)
                begin
                    win_q[g]   <= RST_BYTE;
                    dirty_q[g] <= 1'b0;
                end
                else if (ld_cap && (rd_tag_idx_q == 5'(g)))
                begin
                    win_q[g]   <= NV_RDATA;
                    dirty_q[g] <= 1'b0;
                end
                else if (win_wr && (win_idx == 5'(g)))
                begin
                    win_q[g]   <= CMD_REQ.wdata;
                    dirty_q[g] <= 1'b1;
                end
                else if ((st_q == ST_COMMIT) && (cnt_q == COMMIT_LAST))
                begin
                    dirty_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    nv_window_sum #(.NBYTES(NBYTES)) u_sum (
        .win (win_flat),
        .chk (chk)
    );

    // ----------------------------------------
    // Security mode and key sequence
    // ----------------------------------------
    always_comb
    begin
        sec_d      = sec_q;
        key_step_d = key_step_q;
        if (word_stb)
        begin
            key_step_d = 2'd0;
            if (sealed && ukey0_hit)
                key_step_d = 2'd1;
            else if ((sec_q == SEC_OPEN_MODE) && fkey0_hit)
                key_step_d = 2'd2;
            if (unseal_ok)
                sec_d = SEC_OPEN_MODE;
            else if (full_ok)
                sec_d = SEC_FULL;
            else if ((word == SUBCMD_SEAL) && open_mode)
                sec_d = SEC_SEALED;
            else if ((word == SUBCMD_BOOT) && (sec_q == SEC_FULL))
                sec_d = SEC_BOOT;
        end
    end

    // ----------------------------------------
    // Load and commit sequencer
    // ----------------------------------------
    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            ST_IDLE:
            begin
                cnt_d = CNT_RST;
                if (load_go)
                    st_d = ST_LOAD;
                else if (commit_go)
                    st_d = ST_COMMIT;
            end
            ST_LOAD:
            begin
                cnt_d = 6'(cnt_q + 6'h01);
                if (cnt_q == LOAD_LAST)
                    st_d = ST_IDLE;
            end
            ST_COMMIT:
            begin
                cnt_d = 6'(cnt_q + 6'h01);
                if (cnt_q == COMMIT_LAST)
                    st_d = ST_IDLE;
            end
        endcase
        nv_d       = NV_REQ_RST;
        nv_d.rd    = (st_q == ST_LOAD) && (cnt_q < 6'(NBYTES));
        nv_d.wr    = (st_q == ST_COMMIT) && dirty_q[cnt_q[4:0]];
        nv_d.addr  = {page_sub_q, page_blk_q, cnt_q[4:0]};
        nv_d.wdata = win_q[cnt_q[4:0]];
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb
    begin
        rdata_d = RST_BYTE;
        if (in_win && win_ok)
            rdata_d = win_q[win_idx];
        else if (CMD_REQ.addr == CMD_SUBCMD_LO)
            rdata_d = {5'h00, (sec_q == SEC_BOOT), (sec_q != SEC_FULL), sealed};
        else if (CMD_REQ.addr == CMD_SUBCLASS)
            rdata_d = subclass_q;
        else if (CMD_REQ.addr == CMD_BLOCK)
            rdata_d = block_q;
        else if ((CMD_REQ.addr == CMD_CHECKSUM) && win_ok)
            rdata_d = chk;
        else if (CMD_REQ.addr == CMD_WIN_MODE)
            rdata_d = mode_sel_q;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sec_q         <= SEC_SEALED;
            st_q          <= ST_IDLE;
            cnt_q         <= CNT_RST;
            key_step_q    <= 2'd0;
            sub_lo_q      <= RST_BYTE;
            subclass_q    <= RST_BYTE;
            block_q       <= RST_BYTE;
            mode_sel_q    <= RST_BYTE;
            page_sub_q    <= RST_BYTE;
            page_blk_q    <= RST_BYTE;
            win_valid_q   <= 1'b0;
            info_a_q      <= 1'b0;
            rd_tag_vld_q  <= 1'b0;
            rd_tag_idx_q  <= 5'h00;
            NV_REQ        <= NV_REQ_RST;
            CMD_RDATA     <= RST_BYTE;
            BUSY          <= 1'b0;
            SEALED_STATUS <= 1'b1;
            FAS_FLAG      <= 1'b1;
            BOOT_MODE     <= 1'b0;
            GAUGE_RESET   <= 1'b0;
        end
        else
        begin
            sec_q         <= sec_d;
            st_q          <= st_d;
            cnt_q         <= cnt_d;
            key_step_q    <= key_step_d;
            NV_REQ        <= nv_d;
            rd_tag_vld_q  <= NV_REQ.rd;
            rd_tag_idx_q  <= NV_REQ.addr[4:0];
            BUSY          <= (st_d != ST_IDLE);
            SEALED_STATUS <= (sec_d == SEC_SEALED);
            FAS_FLAG      <= (sec_d != SEC_FULL);
            BOOT_MODE     <= (sec_d == SEC_BOOT);
            // Mode is kept across the reset subcommand, so a locked part stays locked
            GAUGE_RESET   <= word_stb && (word == SUBCMD_RESET);
            if (CMD_REQ.rd)
                CMD_RDATA <= rdata_d;
            if (wr_ok && (CMD_REQ.addr == CMD_SUBCMD_LO))
                sub_lo_q <= CMD_REQ.wdata;
            if (wr_ok && (CMD_REQ.addr == CMD_SUBCLASS) && open_mode)
                subclass_q <= CMD_REQ.wdata;
            if (wr_ok && (CMD_REQ.addr == CMD_WIN_MODE) && (sec_q != SEC_BOOT))
                mode_sel_q <= CMD_REQ.wdata;
            if (blk_wr)
            begin
                block_q     <= CMD_REQ.wdata;
                win_valid_q <= 1'b0;
            end
            if (load_go)
            begin
                // Info block n lives at slice n-1 of the info subclass
                page_sub_q <= info_sel ? INFO_SUBCLASS : subclass_q;
                page_blk_q <= info_sel ? 8'(CMD_REQ.wdata - INFO_IDX_A) : CMD_REQ.wdata;
                info_a_q   <= info_sel && (CMD_REQ.wdata == INFO_IDX_A);
            end
            if ((st_q == ST_LOAD) && (cnt_q == LOAD_LAST))
                win_valid_q <= 1'b1;
            if (word_stb && (sec_d == SEC_BOOT))
                win_valid_q <= 1'b0;
        end
    end

    // Key words follow the window after a permitted commit of the key page
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ukey0_q <= UNSEAL_KEY0;
            ukey1_q <= UNSEAL_KEY1;
            fkey0_q <= FULL_KEY0;
            fkey1_q <= FULL_KEY1;
        end
        else if (commit_go && key_page)
        begin
            ukey0_q <= {win_q[0], win_q[1]};
            ukey1_q <= {win_q[2], win_q[3]};
            fkey0_q <= {win_q[4], win_q[5]};
            fkey1_q <= {win_q[6], win_q[7]};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_SEAL_MOVES: assert property (@(posedge CLK) disable iff (!RST_N)
        (word_stb && (word == SUBCMD_SEAL) && open_mode) |=> (sec_q == SEC_SEALED) && SEALED_STATUS)
        else $error("seal subcommand did not lock");
    AST_SUBCLASS_LOCKED: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_ok && (CMD_REQ.addr == CMD_SUBCLASS) && sealed) |=> $stable(subclass_q))
        else $error("subclass changed while locked");
    AST_BAD_CHECKSUM: assert property (@(posedge CLK) disable iff (!RST_N)
        (chk_wr && (CMD_REQ.wdata != chk)) |=> (st_q == ST_IDLE) && !NV_REQ.wr)
        else $error("commit started on wrong checksum");
    AST_GOOD_CHECKSUM: assert property (@(posedge CLK) disable iff (!RST_N)
        (chk_wr && win_valid_q && !sealed && !key_page && (CMD_REQ.wdata == chk) && !load_go)
        |=> (st_q == ST_COMMIT) ##32 (st_q == ST_IDLE))
        else $error("valid checksum did not commit in 32 cycles");
    AST_RESET_KEEPS_SEAL: assert property (@(posedge CLK) disable iff (!RST_N)
        (word_stb && (word == SUBCMD_RESET) && sealed) |=> GAUGE_RESET && (sec_q == SEC_SEALED))
        else $error("reset subcommand lost locked mode");
    AST_INFO_A_RO: assert property (@(posedge CLK) disable iff (!RST_N)
        (CMD_REQ.wr && in_win && sealed && info_a_q && (st_q == ST_IDLE)) |=> $stable(win_flat))
        else $error("info block A written while locked");
    AST_BOOT_ONLY_FULL: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(BOOT_MODE) |-> ($past(sec_q, 2) == SEC_FULL))
        else $error("boot mode entered from a mode other than full access");
    AST_SS_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
        unseal_ok |=> !SEALED_STATUS && (key_step_q == 2'd0))
        else $error("sealed status not cleared by open keys");
    AST_FAS_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N)
        full_ok |=> !FAS_FLAG ##1 !FAS_FLAG)
        else $error("unrestricted flag not cleared by keys");
    AST_SHORT_BLOCK: assert property (@(posedge CLK) disable iff (!RST_N)
        ((st_q == ST_COMMIT) && !dirty_q[cnt_q[4:0]]) |=> !NV_REQ.wr)
        else $error("unwritten byte committed");
    AST_KEY_VOID: assert property (@(posedge CLK) disable iff (!RST_N)
        (word_stb && !ukey0_hit && !fkey0_hit) |=> (key_step_q == 2'd0))
        else $error("key sequence survived another word");

endmodule // nv_window_access

// [test/nv_mem_model.sv]
// Behavioural parameter memory on the far side of the window block
`timescale 1ns/1ps
module nv_mem_model
    import nv_access_pkg::*;
(
    // Clock
    input  wire logic       CLK,
    // Memory port
    input  wire nv_req_s    NV_REQ,
    output      logic [7:0] NV_RDATA
);
    logic [7:0] mem [logic [20:0]];
    int         wcount = 0;

    initial NV_RDATA = 8'h00;

    // Unwritten cells read a pattern tied to their address
    function automatic logic [7:0] get(input logic [20:0] a);
        return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5A);
    endfunction

    // Data only in the cycle after the strobe; toggling garbage otherwise
    always @(posedge CLK)
    begin
        NV_RDATA <= NV_REQ.rd ? get(NV_REQ.addr) : ~NV_RDATA;
        if (NV_REQ.wr)
        begin
            mem[NV_REQ.addr] = NV_REQ.wdata;
            wcount++;
        end
    end
endmodule // nv_mem_model

// [test/tb_top.sv]
// Self-checking bench for the parameter-memory window block
`timescale 1ns/1ps
module tb_top
    import nv_access_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [15:0] UK0 = 16'h1234, UK1 = 16'h5678, FK0 = 16'h9ABC, FK1 = 16'hDEF1;
    typedef struct {logic [7:0] mode; logic [7:0] sub; logic [7:0] blk; logic [20:0] nva;} row_s;
    row_s rows [3] = '{'{8'h00, 8'h50, 8'h01, {8'h50, 8'h01, 5'h00}},
                       '{8'h00, 8'h3A, 8'h00, {8'h3A, 8'h00, 5'h00}},
                       '{8'h01, 8'h3A, 8'h03, {8'h3A, 8'h02, 5'h00}}};
    logic        CLK = 1'b0;
    logic        RST_N = 1'b0;
    cmd_req_s    CMD_REQ = '0;
    logic [7:0]  CMD_RDATA, NV_RDATA, rv, v, cs;
    nv_req_s     NV_REQ;
    logic        BUSY, SEALED_STATUS, FAS_FLAG, BOOT_MODE, GAUGE_RESET;
    logic [20:0] fa;
    int          err_count = 0, checks = 0, gr = 0, n;

    always #10 CLK = ~CLK;
    always @(posedge CLK) if (GAUGE_RESET === 1'b1) gr++;

    nv_window_access #(.UNSEAL_KEY0(UK0), .UNSEAL_KEY1(UK1), .FULL_KEY0(FK0), .FULL_KEY1(FK1)) DUT (
        .CLK(CLK), .RST_N(RST_N), .CMD_REQ(CMD_REQ), .CMD_RDATA(CMD_RDATA), .NV_REQ(NV_REQ),
        .NV_RDATA(NV_RDATA), .BUSY(BUSY), .SEALED_STATUS(SEALED_STATUS), .FAS_FLAG(FAS_FLAG),
        .BOOT_MODE(BOOT_MODE), .GAUGE_RESET(GAUGE_RESET));
    nv_mem_model mem_i (.CLK(CLK), .NV_REQ(NV_REQ), .NV_RDATA(NV_RDATA));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_addr(input string what, input logic [20:0] e, input logic [20:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        CMD_REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge CLK);
        CMD_REQ = '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge CLK);
        CMD_REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge CLK);
        CMD_REQ = '0;
        d = CMD_RDATA;
    endtask

    // Low byte first; the high byte completes the word
    task automatic subcmd(input logic [15:0] w);
        wr(CMD_SUBCMD_LO, w[7:0]);
        wr(CMD_SUBCMD_HI, w[15:8]);
        repeat (2) @(negedge CLK);
    endtask

    task automatic key(input logic [15:0] k);
        subcmd({k[7:0], k[15:8]});
    endtask

    // Waits out a load or commit, noting the first memory read address
    task automatic settle(output logic [20:0] a);
        int i;
        a = '1;
        for (i = 0; i < 100 && (BUSY !== 1'b0 || i < 3); i++)
        begin
            @(negedge CLK);
            if (NV_REQ.rd === 1'b1 && a === '1) a = NV_REQ.addr;
        end
        if (i == 100)
        begin
            chk_byte("busy wait", 8'h00, {7'h00, BUSY});
            summarize();
        end
    endtask

    task automatic mode_chk(input logic [2:0] e);
        chk_byte("status pins", {5'h00, e}, {5'h00, BOOT_MODE, FAS_FLAG, SEALED_STATUS});
        rd(CMD_SUBCMD_LO, rv);
        chk_byte("status word", {5'h00, e}, rv);
    endtask

    function automatic logic [7:0] csum(input logic [20:0] b, input int off, input logic [7:0] val);
        logic [7:0] s = 8'h00;
        for (int i = 0; i < WIN_BYTES; i++) s += (i == off) ? val : mem_i.get(b + 21'(i));
        return CHECK_FULL - s;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(negedge CLK);
        RST_N = 1'b1;
        chk_byte("busy after reset", 8'h00, {7'h00, BUSY});
        mode_chk(3'b011);
        key(UK0);
        key(UK1);
        mode_chk(3'b010);
        $display("test unseal done");
        foreach (rows[r])
        begin
            wr(CMD_WIN_MODE, rows[r].mode);
            wr(CMD_SUBCLASS, rows[r].sub);
            wr(CMD_BLOCK, rows[r].blk);
            settle(fa);
            chk_addr("load address", rows[r].nva, fa);
            rd(8'h50, rv);
            chk_byte("window byte", mem_i.get(rows[r].nva + 21'd16), rv);
            v = 8'hFF - 8'(r);
            wr(8'h50, v);
            cs = csum(rows[r].nva, 16, v);
            rd(CMD_CHECKSUM, rv);
            chk_byte("checksum read", cs, rv);
            n = mem_i.wcount;
            wr(CMD_CHECKSUM, ~cs);
            settle(fa);
            chk_byte("bad commit writes", 8'h00, 8'(mem_i.wcount - n));
            wr(CMD_CHECKSUM, cs);
            settle(fa);
            chk_byte("commit writes", 8'h01, 8'(mem_i.wcount - n));
            chk_byte("stored byte", v, mem_i.get(rows[r].nva + 21'd16));
            $display("test row %0d done", r);
        end
        subcmd(SUBCMD_BOOT);
        mode_chk(3'b010);
        key(FK0);
        key(FK1);
        mode_chk(3'b000);
        subcmd(SUBCMD_RESET);
        chk_byte("reset pulses", 8'h01, 8'(gr));
        subcmd(SUBCMD_SEAL);
        mode_chk(3'b011);
        $display("test modes done");
        // Locked: subclass write must not stick
        wr(CMD_SUBCLASS, 8'h44);
        wr(CMD_BLOCK, INFO_IDX_A);
        settle(fa);
        chk_addr("info A address", {INFO_SUBCLASS, 8'h00, 5'h00}, fa);
        wr(CMD_WIN_BASE, 8'hC3);
        rd(CMD_WIN_BASE, rv);
        chk_byte("info A byte", mem_i.get({INFO_SUBCLASS, 8'h00, 5'h00}), rv);
        wr(CMD_BLOCK, 8'h02);
        settle(fa);
        chk_addr("info B address", {INFO_SUBCLASS, 8'h01, 5'h00}, fa);
        wr(8'h45, 8'h77);
        wr(CMD_CHECKSUM, csum(fa, 5, 8'h77));
        settle(fa);
        chk_byte("info B stored", 8'h77, mem_i.get({INFO_SUBCLASS, 8'h01, 5'h05}));
        subcmd(SUBCMD_RESET);
        chk_byte("reset pulses", 8'h02, 8'(gr));
        mode_chk(3'b011);
        key(UK0);
        subcmd(SUBCMD_SEAL);
        key(UK1);
        mode_chk(3'b011);
        key(UK0);
        key(UK1);
        wr(CMD_WIN_MODE, WIN_MODE_GENERAL);
        wr(CMD_BLOCK, 8'h00);
        settle(fa);
        chk_addr("subclass kept", {INFO_SUBCLASS, 8'h00, 5'h00}, fa);
        $display("test locked done");
        // Key page: commit refused while only open, taken in full access
        wr(CMD_SUBCLASS, KEY_SUBCLASS);
        wr(CMD_BLOCK, 8'h00);
        settle(fa);
        wr(CMD_WIN_BASE, 8'h11);
        cs = csum(fa, 0, 8'h11);
        n = mem_i.wcount;
        wr(CMD_CHECKSUM, cs);
        settle(fa);
        chk_byte("key page open", 8'h00, 8'(mem_i.wcount - n));
        key(FK0);
        key(FK1);
        wr(CMD_CHECKSUM, cs);
        settle(fa);
        chk_byte("key page full", 8'h01, 8'(mem_i.wcount - n));
        $display("test key page done");
        subcmd(SUBCMD_BOOT);
        chk_byte("boot pin", 8'h01, {7'h00, BOOT_MODE});
        wr(CMD_BLOCK, 8'h00);
        repeat (3) @(negedge CLK);
        chk_byte("busy in boot", 8'h00, {7'h00, BUSY});
        $display("test boot done");
        summarize();
    end
endmodule // tb_top
